// >>> input_port_and_io_port_pair_test.sv
// Purpose: self-checking bench for port_pair
// Assumes: released io pins follow ext
// Notes: outputs judged at the falling edge, clear of updates
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
$display("MISMATCH %0t %h %h", $time, a, b); end end
module input_port_and_io_port_pair_test;
	logic i_clk = 0, i_rst = 1, hw = 0, sw = 0;
	logic [7:0] in_pins = 8'h00, rdata, analog;
	logic [4:0] ext = 5'h0b, pins, out, oe_n;
	logic [3:0] irq;
	port_pair_pkg::bus_req_t bus = '0;
	port_pair_pkg::pin_func_t func = 6'h1a; // selects 0110, strobe high
	int num_errors = 0, checked = 0, cycles = 0;
	port_pair uut (.i_clk(i_clk), .i_rst(i_rst), .i_hw_standby(hw),
		.i_sw_standby(sw), .i_bus(bus), .o_rdata(rdata), .i_in_pins(in_pins),
		.o_analog_in(analog), .i_func(func), .i_io_pins(pins), .o_io_out(out),
		.o_io_oe_n(oe_n), .o_ext_interrupt_n(irq));
	pin_world world (.i_io_out(out), .i_io_oe_n(oe_n), .i_ext(ext),
		.o_pins(pins));
	always #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 1000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up;
		if (num_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic edges(int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge i_clk);
		bus <= {a, d, 2'b10};
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e);
		@(posedge i_clk);
		bus <= {a, 8'h00, 2'b01};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		@(negedge i_clk);
		`CHK(rdata, e)
	endtask
	task automatic t_reset;
		rd(16'hffcd, 8'hff);
		rd(16'hffcf, 8'heb);
		`CHK(oe_n, 5'h0f)
		`CHK(irq, 4'hb)
	endtask
	task automatic t_input;
		@(posedge i_clk);
		in_pins <= 8'ha5;
		edges(4);
		wr(16'hffce, 8'h00);
		rd(16'hffce, 8'ha5);
		`CHK(analog, 8'ha5)
		rd(16'hffd0, 8'h00);
	endtask
	task automatic t_chip_select;
		wr(16'hffcd, 8'h1f);
		wr(16'hffcf, 8'h01);
		rd(16'hffcf, 8'he1);
		edges(3);
		@(negedge i_clk);
		`CHK(oe_n, 5'h00)
		`CHK(out, 5'h0d)
		`CHK(irq, 4'hd)
	endtask
	task automatic t_refresh;
		wr(16'hffcd, 8'h00);
		@(posedge i_clk);
		func <= 6'h19;
		edges(3);
		rd(16'hffcf, 8'hea);
		`CHK(oe_n, 5'h1e)
		`CHK(out[0], 1'b0)
		@(posedge i_clk);
		func <= 6'h1a;
		edges(2);
		@(negedge i_clk);
		`CHK(oe_n, 5'h1f)
	endtask
	task automatic t_standby;
		wr(16'hffcd, 8'h1f);
		@(posedge i_clk);
		sw <= 1'b1;
		@(posedge i_clk);
		func <= 6'h26;
		edges(3);
		@(negedge i_clk);
		`CHK(out, 5'h0d)
		@(posedge i_clk);
		sw <= 1'b0;
		edges(2);
		@(negedge i_clk);
		`CHK(out, 5'h13)
		@(posedge i_clk);
		hw <= 1'b1;
		edges(2);
		@(negedge i_clk);
		`CHK(oe_n, 5'h1f)
		@(posedge i_clk);
		hw <= 1'b0;
		rd(16'hffcf, 8'heb);
		`CHK(oe_n, 5'h0f)
	endtask
	initial begin
		edges(3);
		i_rst <= 1'b0;
		t_reset();
		t_input();
		t_chip_select();
		t_refresh();
		t_standby();
		wrap_up();
	end
endmodule

// >>> pin_world.sv
// Purpose: outside world on the io port pins
// Assumes: an outside source drives every released pin
// Notes: released pins never keep the device's last drive
`timescale 1ns/1ns
module pin_world (
	input wire logic [4:0] i_io_out, i_io_oe_n, i_ext,
	output logic [4:0] o_pins
);
	assign o_pins = (i_io_oe_n & i_ext) | (~i_io_oe_n & i_io_out);
endmodule

// >>> port_pair.sv
// Purpose: input-only port and five-pin io port with shared pin functions
// Assumes: pin levels are asynchronous; chip selects and refresh strobe
//   come from logic on i_clk
// Notes: pin drive is registered, so shared functions reach the pins one
//   cycle after they change inside the chip
`timescale 1ns/1ns
module port_pair (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// power states
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	// register port
	input wire port_pair_pkg::bus_req_t i_bus,
	output logic [7:0] o_rdata,
	// input-only port pins and analog feed
	input wire logic [7:0] i_in_pins,
	output logic [7:0] o_analog_in,
	// shared functions from the bus and refresh controllers
	input wire port_pair_pkg::pin_func_t i_func,
	// io port pins
	input wire logic [4:0] i_io_pins,
	output logic [4:0] o_io_out,
	output logic [4:0] o_io_oe_n,
	// interrupt request levels toward the interrupt controller
	output logic [3:0] o_ext_interrupt_n
);

	localparam int IOW = port_pair_pkg::IO_PINS;

	function automatic logic hit(input logic [15:0] addr,
		input logic [15:0] where);
		hit = (addr == where);
	endfunction

	// synchronised pin levels
	logic [7:0] in_levels;
	logic [4:0] io_levels;

	// registers
	logic [4:0] io_dir_reg;
	logic [4:0] io_dir_next;
	logic [4:0] io_latch_reg;
	logic [4:0] io_latch_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// pin drive and forwarded levels
	logic [4:0] io_out_reg;
	logic [4:0] io_out_next;
	logic [4:0] io_oe_n_reg;
	logic [4:0] io_oe_n_next;
	logic [7:0] analog_reg;
	logic [7:0] analog_next;
	logic [3:0] irq_reg;
	logic [3:0] irq_next;
	logic [1:0] warm_reg;
	logic [1:0] warm_next;

	logic reg_clear;
	logic [4:0] io_read;

	sync2 #(
		.WIDTH(8)
	) u_in_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_in_pins),
		.o_sync(in_levels)
	);

	sync2 #(
		.WIDTH(IOW)
	) u_io_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_io_pins),
		.o_sync(io_levels)
	);

	// hardware standby loads the register reset values like the system reset, but releases every pin
	assign reg_clear = i_hw_standby;

	// register writes; software standby leaves them untouched
	always_comb begin
		io_dir_next = io_dir_reg;
		io_latch_next = io_latch_reg;
		if (reg_clear) begin
			io_dir_next = port_pair_pkg::IO_DIR_RESET[4:0];
			io_latch_next = port_pair_pkg::IO_LATCH_RESET[4:0];
		end else if (i_bus.wr) begin
			if (hit(i_bus.addr, port_pair_pkg::ADDR_IO_DIR)) begin
				io_dir_next = i_bus.wdata[4:0];
			end else if (hit(i_bus.addr, port_pair_pkg::ADDR_IO_LATCH)) begin
				// bits 7 to 5 have no storage, so writes to them vanish
				io_latch_next = i_bus.wdata[4:0];
			end
			// the input-level address has no storage behind it
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			io_dir_reg <= port_pair_pkg::IO_DIR_RESET[4:0];
			io_latch_reg <= port_pair_pkg::IO_LATCH_RESET[4:0];
		end else begin
			io_dir_reg <= io_dir_next;
			io_latch_reg <= io_latch_next;
		end
	end

	// per-pin read value: latch where the direction bit is one, live level where it is zero
	always_comb begin
		for (int i = 0; i < IOW; i++) begin
			io_read[i] = io_dir_reg[i] ? io_latch_reg[i] : io_levels[i];
		end
	end

	// read data stands only in the cycle after the strobe
	always_comb begin
		rdata_next = port_pair_pkg::UNMAPPED_READ;
		if (i_bus.rd) begin
			if (hit(i_bus.addr, port_pair_pkg::ADDR_IO_DIR)) begin
				rdata_next = port_pair_pkg::IO_DIR_READ;
			end else if (hit(i_bus.addr, port_pair_pkg::ADDR_IN_LEVELS)) begin
				rdata_next = in_levels;
			end else if (hit(i_bus.addr, port_pair_pkg::ADDR_IO_LATCH)) begin
				rdata_next = port_pair_pkg::RESERVED_ONES | {3'h0, io_read};
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= port_pair_pkg::UNMAPPED_READ;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// pin function selection; no mode input exists, so it is the same in
	// every operating mode
	always_comb begin
		io_out_next = io_out_reg;
		io_oe_n_next = io_oe_n_reg;
		if (reg_clear) begin
			// hardware standby releases every pin
			io_out_next = 5'h00;
			io_oe_n_next = 5'h1f;
		end else if (!i_sw_standby) begin
			for (int k = port_pair_pkg::PIN_CS_LOW;
				k <= port_pair_pkg::PIN_CS_HIGH; k++) begin
				// pin 4 carries select 0 down to pin 1 carrying select 3
				io_out_next[k] = i_func.chip_select_n[4 - k];
				io_oe_n_next[k] = ~io_dir_reg[k];
			end
			if (i_func.refresh_pin_enable) begin
				io_out_next[0] = i_func.refresh_strobe_n;
				io_oe_n_next[0] = 1'b0;
			end else begin
				io_out_next[0] = io_latch_reg[0];
				io_oe_n_next[0] = ~io_dir_reg[0];
			end
		end
		// in software standby the drive state is frozen as it stands
	end

	// forwarded levels: analog feed and interrupt inputs sample in parallel
	// with whatever function the pin has
	always_comb begin
		analog_next = in_levels;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			analog_reg <= 8'h00;
		end else begin
			analog_reg <= analog_next;
		end
	end

	// the synchronisers leave reset at zero, which on active-low request
	// lines would look like four asserted interrupts; hold the requests
	// idle until real pin levels have reached the second stage
	always_comb begin
		warm_next = warm_reg;
		irq_next = 4'hf;
		if (warm_reg != port_pair_pkg::SYNC_WARMUP) begin
			warm_next = warm_reg + 2'h1;
		end else begin
			irq_next = io_levels[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_reg <= 4'hf;
			warm_reg <= 2'h0;
		end else begin
			irq_reg <= irq_next;
			warm_reg <= warm_next;
		end
	end

	// pin drive registers; reset drives pin 4 because its direction bit
	// comes out of reset set
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			io_out_reg <= 5'h00;
			io_oe_n_reg <= ~port_pair_pkg::IO_DIR_RESET[4:0];
		end else begin
			io_out_reg <= io_out_next;
			io_oe_n_reg <= io_oe_n_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_io_out = io_out_reg;
	assign o_io_oe_n = io_oe_n_reg;
	assign o_analog_in = analog_reg;
	assign o_ext_interrupt_n = irq_reg;

endmodule

// >>> port_pair_pkg.sv
// Purpose: shared constants and types for the input port / io port pair
// Assumes: byte-wide internal bus, low 16 address bits decoded
// Notes: register reset values apply at system reset and hardware standby
//
// Operation
// - first port is eight input-only pins with no direction register.
// - reading first port data always returns live pin levels, no reset.
// - first port pins also feed the analog converter inputs.
// - pin function selection never depends on the operating mode.
// - second port has five usable pins, bits 4 to 0, each in or out.
// - direction register is write-only and always reads all ones.
// - direction register resets to f0, kept in software standby.
// - in software standby output pins keep their present drive.
// - direction bits 4..1 give chip selects 0..3, bit 0 plain output.
// - data read gives latch where direction is one, pin otherwise.
// - data bits 7 to 5 ignore writes and always read one.
// - data register resets to e0 and is kept in software standby.
// - pins carry chip selects, refresh strobe and four interrupt inputs.
package port_pair_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int IN_PINS = 8;
	localparam int IO_PINS = 5;
	localparam int CS_COUNT = 4;
	localparam int IRQ_COUNT = 4;

	// register byte addresses
	localparam logic [15:0] ADDR_IO_DIR = 16'hffcd;
	localparam logic [15:0] ADDR_IN_LEVELS = 16'hffce;
	localparam logic [15:0] ADDR_IO_LATCH = 16'hffcf;

	// reset values and fixed read patterns
	localparam logic [7:0] IO_DIR_RESET = 8'hf0;
	localparam logic [7:0] IO_LATCH_RESET = 8'he0;
	localparam logic [7:0] IO_DIR_READ = 8'hff;
	localparam logic [7:0] RESERVED_ONES = 8'he0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// cycles after reset before the pin synchronisers hold real levels
	localparam logic [1:0] SYNC_WARMUP = 2'h2;

	// field positions on the io port
	localparam int PIN_PLAIN = 0;
	localparam int PIN_CS_LOW = 1;
	localparam int PIN_CS_HIGH = 4;
	localparam int USED_MSB = 4;
	localparam int RESERVED_LSB = 5;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic [CS_COUNT-1:0] chip_select_n;
		logic refresh_strobe_n;
		logic refresh_pin_enable;
	} pin_func_t;

endpackage

// >>> port_pair_props.sv
// Purpose: checker on port_pair ports
// Assumes: one clock domain
// Notes: pin paths judged once inputs sit still
`timescale 1ns/1ns
module port_pair_props (
	input wire logic i_clk, i_rst, i_hw_standby, i_sw_standby,
	input wire port_pair_pkg::bus_req_t i_bus,
	input wire port_pair_pkg::pin_func_t i_func,
	input wire logic [7:0] o_rdata, i_in_pins, o_analog_in,
	input wire logic [4:0] i_io_pins, o_io_out, o_io_oe_n,
	input wire logic [3:0] o_ext_interrupt_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [1:0] run_reg;
	// pin drive is registered, so trust it only after two plain cycles
	always_ff @(posedge i_clk) begin
		run_reg <= {run_reg[0], !(i_rst | i_hw_standby | i_sw_standby)};
	end
	chk_dir_ones: assert property (
		i_bus.rd && i_bus.addr == 16'hffcd |=> o_rdata == 8'hff) else $error("dir");
	chk_latch_top: assert property (
		i_bus.rd && i_bus.addr == 16'hffcf |=> o_rdata[7:5] == 3'h7)
		else $error("rsv");
	chk_analog_feed: assert property (
		(!i_hw_standby && $stable(i_in_pins))[*5] |-> o_analog_in == i_in_pins)
		else $error("analog");
	chk_irq_follow: assert property (
		(!i_hw_standby && $stable(i_io_pins))[*5]
		|-> o_ext_interrupt_n == i_io_pins[3:0]) else $error("irq");
	chk_hw_release: assert property (
		i_hw_standby ##1 i_hw_standby |=> o_io_oe_n == 5'h1f && o_io_out == 5'h00)
		else $error("hw");
	chk_sw_freeze: assert property (
		i_sw_standby && !i_hw_standby |=> $stable(o_io_out) && $stable(o_io_oe_n))
		else $error("sw");
	chk_cs_route: assert property (
		&run_reg && !o_io_oe_n[4] |-> o_io_out[4] == $past(i_func.chip_select_n[0]))
		else $error("cs");
	chk_refresh_pin: assert property (
		&run_reg && $past(i_func.refresh_pin_enable) |-> !o_io_oe_n[0]
		&& o_io_out[0] == $past(i_func.refresh_strobe_n)) else $error("refresh_strobe_n");
	chk_irq_quiet: assert property (
		$past(i_rst) |-> o_ext_interrupt_n == 4'hf ##1 o_ext_interrupt_n == 4'hf)
		else $error("irq reset");
	cover property (i_sw_standby ##1 i_sw_standby);
	cover property (i_func.refresh_pin_enable && !o_io_oe_n[0]);
	cover property (o_io_oe_n == 5'h00);
endmodule
bind port_pair port_pair_props chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_hw_standby(i_hw_standby), .i_sw_standby(i_sw_standby), .i_bus(i_bus),
	.i_func(i_func), .o_rdata(o_rdata), .i_in_pins(i_in_pins),
	.o_analog_in(o_analog_in), .i_io_pins(i_io_pins), .o_io_out(o_io_out),
	.o_io_oe_n(o_io_oe_n), .o_ext_interrupt_n(o_ext_interrupt_n));

// >>> sync2.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: each bit is an independent level, not a bus word
// Notes: only the second stage leaves this module
`timescale 1ns/1ns
module sync2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;

endmodule
